// *** src/wss_pkg.sv ***
package wss_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] WSS_OFF_CTRL0  = 12'h000;
    localparam logic [11:0] WSS_OFF_SRCSEL = 12'h004;
    localparam logic [11:0] WSS_OFF_STEER  = 12'h008;
    localparam logic [11:0] WSS_OFF_MODE   = 12'h00C;
    localparam logic [11:0] WSS_OFF_STATUS = 12'h010;

    // ----------------------------------------------------------------
    // autoshut_ctrl0 fields
    // ----------------------------------------------------------------
    localparam int WSS_C0_SHUTDOWN = 0;
    localparam int WSS_C0_RESTART  = 1;
    localparam int WSS_C0_ASEN     = 2;
    localparam int WSS_C0_ENABLE   = 3;
    localparam int WSS_C0_CLKSEL   = 4;

    // ----------------------------------------------------------------
    // source select fields
    // ----------------------------------------------------------------
    localparam int WSS_SRC_CMP1  = 0;
    localparam int WSS_SRC_CMP2  = 1;
    localparam int WSS_SRC_TMR   = 2;
    localparam int WSS_SRC_FAULT = 3;
    localparam int WSS_NSRC      = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] WSS_RST_CTRL0  = 8'h00;
    localparam logic [7:0] WSS_RST_SRCSEL = 8'h00;
    localparam logic [7:0] WSS_RST_STEER  = 8'h00;
    localparam logic [2:0] WSS_RST_MODE   = 3'h0;
    localparam logic [3:0] WSS_RST_POL    = 4'h0;
    localparam logic [3:0] WSS_RST_SDLVL  = 4'h0;

    // ----------------------------------------------------------------
    // modes
    // ----------------------------------------------------------------
    localparam logic [2:0] WSS_MODE_STEER_SYNC = 3'h1;
    localparam logic [1:0] WSS_MODE_STEER_HI   = 2'h0;

    typedef enum logic [1:0] {
        WSS_RUN  = 2'b01,
        WSS_SHUT = 2'b10
    } wss_state_t;

endpackage

// *** src/wss_sync.sv ***
`timescale 1ns/1ps
module wss_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] d_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1_q;

    // ----------------------------------------------------------------
    // two-stage synchroniser, reset to all ones (inactive low sources)
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_q <= '1;
            q_o  <= '1;
        end
        else if (ce_i)
        begin
            s1_q <= d_i;
            q_o  <= s1_q;
        end
    end

    logic unused_rv;
    assign unused_rv = ^rst_val_i;
endmodule // wss_sync

// *** src/wss_steer.sv ***
`timescale 1ns/1ps
module wss_steer (
    input  wire logic       wave_i,
    input  wire logic [3:0] pol_i,
    input  wire logic [3:0] steer_en_i,
    input  wire logic [3:0] ovr_i,
    input  wire logic       steer_mode_i,
    input  wire logic       shut_i,
    input  wire logic [3:0] shut_lvl_i,
    output logic      [3:0] out_o
);
    // ----------------------------------------------------------------
    // per-output selection
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : g_out
        always_comb
        begin
            if (shut_i)
                out_o[g] = shut_lvl_i[g];                 // [R4]
            else if (steer_mode_i && !steer_en_i[g])      // [R13]
                out_o[g] = ovr_i[g];                      // [R10]
            else
                out_o[g] = wave_i ^ pol_i[g];             // [R10]
        end
    end
endmodule // wss_steer

// *** src/wss_top.sv ***
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
// Functional notes
// R1: writing one to the software shutdown bit forces the shutdown state.
// R2: without auto-restart, shutdown holds while the software bit is set.
// R3: with auto-restart, hardware clears the bit at the next input rise.
// R4: an active enabled source forces outputs to override levels at once.
// R5: every shutdown source is active when low.
// R6: four sources are each enabled in the source select register.
// R7: sources are level sensed; an active level holds shutdown.
// R8: the block runs on its own clock, independent of the system clock.
// R9: in sleep the fast oscillator stays on when enabled, input active, chosen.
// R10: a set steer bit routes the polarity-adjusted waveform, else override.
// R11: in mode 001 the steer enable bits are double-buffered.
// R12: the buffered steer bits load on the next input waveform rise.
// R13: steering bits only act in modes 00x and are ignored otherwise.
module wss_top
    import wss_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        internal_waveform_i,
    input  wire logic        comparator_one_synced_i,
    input  wire logic        comparator_two_synced_i,
    input  wire logic        timer_postscaled_out_i,
    input  wire logic        fault_input_pin_i,
    input  wire logic        sleep_i,
    output logic             wave_output_a_o,
    output logic             wave_output_b_o,
    output logic             wave_output_c_o,
    output logic             wave_output_d_o,
    output logic             fast_osc_keep_o
);
    import wss_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl0_q;
    logic [7:0] srcsel_q;
    logic [7:0] steer_q;
    logic [3:0] steer_act_q;
    logic [2:0] mode_q;
    logic [3:0] pol_q;
    logic [3:0] sdlvl_q;
    logic       wave_q;
    logic       wave_prev_q;
    wss_state_t state_q;
    logic       sleep_s1_q;
    logic       sleep_q;

    logic [3:0] src_raw;
    logic [3:0] src_s;
    logic [3:0] src_act;
    logic       wr;
    logic       rd;
    logic       hit;
    logic       fault_act;
    logic       rise;
    logic       steer_mode;
    logic       shut;
    logic [3:0] out_c;
    logic [31:0] rdata_c;

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    assign src_raw = {fault_input_pin_i, timer_postscaled_out_i,
                      comparator_two_synced_i, comparator_one_synced_i};

    wss_sync #(.WIDTH(WSS_NSRC)) u_sync (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .d_i       (src_raw),
        .rst_val_i ('1),
        .q_o       (src_s)
    );

    // waveform input from same-clock generator logic
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wave_q      <= 1'b0;
            wave_prev_q <= 1'b0;
        end
        else if (ce_i)
        begin
            wave_q      <= internal_waveform_i;
            wave_prev_q <= wave_q;
        end
    end

    assign rise = wave_q & ~wave_prev_q;

    // ----------------------------------------------------------------
    // sleep request comes from the system clock domain
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sleep_s1_q <= 1'b0;
            sleep_q    <= 1'b0;
        end
        else if (ce_i)
        begin
            sleep_s1_q <= sleep_i;
            sleep_q    <= sleep_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign wr  = psel_i & penable_i & pwrite_i & ce_i;
    assign rd  = psel_i & penable_i & ~pwrite_i & ce_i;
    assign hit = (paddr_i == WSS_OFF_CTRL0) || (paddr_i == WSS_OFF_SRCSEL)
              || (paddr_i == WSS_OFF_STEER) || (paddr_i == WSS_OFF_MODE)
              || (paddr_i == WSS_OFF_STATUS);

    // ----------------------------------------------------------------
    // shutdown sources
    // ----------------------------------------------------------------
    for (genvar s = 0; s < WSS_NSRC; s++)
    begin : g_src
        assign src_act[s] = srcsel_q[s] & ~src_s[s];    // [R5] [R6]
    end

    assign fault_act = ctrl0_q[WSS_C0_ASEN] & |src_act; // [R7]

    // ----------------------------------------------------------------
    // control register with software shutdown
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctrl0_q <= WSS_RST_CTRL0;
        else if (ce_i)
        begin
            if (wr && paddr_i == WSS_OFF_CTRL0 && pstrb_i[0])
                ctrl0_q <= pwdata_i[7:0];                       // [R1]
            else if (ctrl0_q[WSS_C0_RESTART] && rise && !fault_act)
                ctrl0_q[WSS_C0_SHUTDOWN] <= 1'b0;               // [R3]
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            srcsel_q <= WSS_RST_SRCSEL;
            mode_q   <= WSS_RST_MODE;
            pol_q    <= WSS_RST_POL;
            sdlvl_q  <= WSS_RST_SDLVL;
        end
        else if (ce_i)
        begin
            if (wr && paddr_i == WSS_OFF_SRCSEL && pstrb_i[0])
                srcsel_q <= {4'h0, pwdata_i[3:0]};              // [R6]
            if (wr && paddr_i == WSS_OFF_MODE && pstrb_i[0])
            begin
                mode_q  <= pwdata_i[2:0];
                pol_q   <= pwdata_i[7:4];
            end
            if (wr && paddr_i == WSS_OFF_MODE && pstrb_i[1])
                sdlvl_q <= pwdata_i[11:8];
        end
    end

    // ----------------------------------------------------------------
    // steering register and its buffered copy
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            steer_q <= WSS_RST_STEER;
        else if (ce_i && wr && paddr_i == WSS_OFF_STEER && pstrb_i[0])
            steer_q <= pwdata_i[7:0];
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            steer_act_q <= WSS_RST_STEER[3:0];
        else if (ce_i)
        begin
            if (mode_q != WSS_MODE_STEER_SYNC)
                steer_act_q <= steer_q[3:0];                    // [R10]
            else if (rise)
                steer_act_q <= steer_q[3:0];                    // [R11] [R12]
        end
    end

    // ----------------------------------------------------------------
    // shutdown state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            state_q <= WSS_RUN;
        else if (ce_i)
        begin
            unique case (state_q)
                WSS_RUN:
                    if (ctrl0_q[WSS_C0_SHUTDOWN] || fault_act)
                        state_q <= WSS_SHUT;
                WSS_SHUT:
                    if (!ctrl0_q[WSS_C0_SHUTDOWN] && !fault_act) // [R2] [R7]
                        state_q <= WSS_RUN;
                default:
                    state_q <= WSS_RUN;
            endcase
        end
    end

    assign shut       = (state_q == WSS_SHUT)                   // [R2]
                      | ctrl0_q[WSS_C0_SHUTDOWN]                // [R1]
                      | fault_act;                              // [R4]
    assign steer_mode = (mode_q[2:1] == WSS_MODE_STEER_HI);     // [R13]

    wss_steer u_steer (
        .wave_i       (wave_q),
        .pol_i        (pol_q),
        .steer_en_i   (steer_act_q),
        .ovr_i        (steer_q[7:4]),
        .steer_mode_i (steer_mode),
        .shut_i       (shut),                                   // [R4]
        .shut_lvl_i   (sdlvl_q),
        .out_o        (out_c)
    );

    // ----------------------------------------------------------------
    // outputs registered; block clock is its own, runs in sleep
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wave_output_a_o <= 1'b0;
            wave_output_b_o <= 1'b0;
            wave_output_c_o <= 1'b0;
            wave_output_d_o <= 1'b0;
            fast_osc_keep_o <= 1'b0;
        end
        else if (ce_i)                                          // [R8]
        begin
            wave_output_a_o <= out_c[0];
            wave_output_b_o <= out_c[1];
            wave_output_c_o <= out_c[2];
            wave_output_d_o <= out_c[3];
            fast_osc_keep_o <= sleep_q && ctrl0_q[WSS_C0_ENABLE]
                            && ctrl0_q[WSS_C0_CLKSEL] && wave_q; // [R9]
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_c = 32'h0000_0000;
        unique case (paddr_i)
            WSS_OFF_CTRL0:  rdata_c[7:0] = ctrl0_q;
            WSS_OFF_SRCSEL: rdata_c[7:0] = srcsel_q;
            WSS_OFF_STEER:  rdata_c[7:0] = steer_q;
            WSS_OFF_MODE:   rdata_c[11:0] = {sdlvl_q, pol_q, 1'b0, mode_q};
            WSS_OFF_STATUS: rdata_c[9:0] = {steer_act_q, src_s,
                                           fault_act, shut};
            default:        rdata_c = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~hit;
            if (psel_i && !penable_i && !pwrite_i)
                prdata_o <= rdata_c;
        end
    end

    logic unused_rd;
    assign unused_rd = rd;
endmodule // wss_top

// *** verif/wss_top_props.sv ***
`timescale 1ns/1ps
module wss_top_props
    import wss_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        internal_waveform_i,
    input wire logic        comparator_one_synced_i,
    input wire logic        comparator_two_synced_i,
    input wire logic        timer_postscaled_out_i,
    input wire logic        fault_input_pin_i,
    input wire logic        sleep_i,
    input wire logic        wave_output_a_o,
    input wire logic        wave_output_b_o,
    input wire logic        wave_output_c_o,
    input wire logic        wave_output_d_o,
    input wire logic        fast_osc_keep_o
);
    // ----------------
    // register shadows
    // ----------------
    logic [4:0]  c0_q;
    logic [3:0]  src_q;
    logic [7:0]  st_q;
    logic [11:0] md_q;
    logic [2:0]  quiet_q;
    logic [3:0]  outs;
    logic [3:0]  pins_n;
    logic        wr;
    logic        en;
    logic        sw_shut;
    logic        src_hit;
    logic        run_ok;
    logic        idle_ok;
    assign wr = ce_i && psel_i && penable_i && pwrite_i && pready_o;
    assign outs = {wave_output_d_o, wave_output_c_o, wave_output_b_o,
                   wave_output_a_o};
    assign pins_n = {fault_input_pin_i, timer_postscaled_out_i,
                     comparator_two_synced_i, comparator_one_synced_i};
    assign en = ce_i && c0_q[WSS_C0_ENABLE];
    assign sw_shut = en && c0_q[WSS_C0_SHUTDOWN] && !c0_q[WSS_C0_RESTART];
    assign src_hit = en && c0_q[WSS_C0_ASEN] && |(src_q & ~pins_n);
    assign run_ok = en && c0_q[2:0] == 3'h0 && md_q[2:0] == 3'h0
                    && quiet_q > 3'h2;
    assign idle_ok = en && c0_q[2:0] == 3'h0 && md_q[2:1] != 2'h0
                     && quiet_q > 3'h2;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            quiet_q <= 3'h0;
        else if (wr || !ce_i)
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            c0_q <= 5'h00;
            src_q <= 4'h0;
            st_q <= 8'h00;
            md_q <= 12'h000;
        end
        else if (wr)
            case (paddr_i)
                WSS_OFF_CTRL0:  c0_q <= pwdata_i[4:0];
                WSS_OFF_SRCSEL: src_q <= pwdata_i[3:0];
                WSS_OFF_STEER:  st_q <= pwdata_i[7:0];
                WSS_OFF_MODE:   md_q <= pwdata_i[11:0];
                default: ;
            endcase
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence setup_s;
        psel_i && !penable_i && ce_i;
    endsequence
    sequence src_low_s;
        src_hit [*4];
    endsequence
    answer_a: assert property (setup_s |=> pready_o)
        else $error("no answer after setup");
    pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    slverr_a: assert property (pready_o |-> pslverr_o ==
        (paddr_i[1:0] != 2'h0 || paddr_i > WSS_OFF_STATUS))
        else $error("error response wrong");
    rst_quiet_a: assert property ($fell(rst_i) |-> outs == 4'h0 && !pready_o)
        else $error("outputs not quiet after reset");
    src_shut_a: assert property (src_low_s |-> outs == md_q[11:8])
        else $error("source did not force override");
    sw_hold_a: assert property (sw_shut [*3] |-> outs == md_q[11:8])
        else $error("software shutdown not held");
    steer_route_a: assert property (run_ok |-> outs == (
        (st_q[3:0] & ({4{$past(internal_waveform_i, 2)}} ^ md_q[7:4]))
        | (~st_q[3:0] & st_q[7:4])))
        else $error("steered outputs wrong");
    steer_ignore_a: assert property (idle_ok |->
        outs == ({4{$past(internal_waveform_i, 2)}} ^ md_q[7:4]))
        else $error("steering not ignored");
    keep_on_a: assert property (
        (en && c0_q[WSS_C0_CLKSEL] && sleep_i && internal_waveform_i) [*4]
        |-> fast_osc_keep_o) else $error("oscillator dropped in sleep");
    keep_off_a: assert property ((ce_i && !sleep_i) [*4] |-> !fast_osc_keep_o)
        else $error("oscillator kept while awake");
endmodule // wss_top_props
bind wss_top wss_top_props u_props (.*);

// *** verif/wss_gate_drv.sv ***
`timescale 1ns/1ps
module wss_gate_drv (
    input  wire logic trip_i,
    output logic      fault_n_o
);
    // fault line driven high when idle, driven low on a trip
    assign fault_n_o = !trip_i;
endmodule // wss_gate_drv

// *** verif/wss_top_tb_top.sv ***
`timescale 1ns/1ps
module wss_top_tb_top;
    import wss_pkg::*;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        psel_i = 1'h0;
    logic        penable_i = 1'h0;
    logic        pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic [31:0] rd;
    logic [3:0]  src_n = 4'hF;
    logic        wave = 1'h0;
    logic        sleep = 1'h0;
    logic        ce = 1'h1;
    logic        err;
    logic        fault_n;
    logic        pready_o;
    logic        pslverr_o;
    logic [3:0]  outs;
    logic        keep;
    int          miscompares = 0;
    int          checks_done = 0;
    wss_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .internal_waveform_i(wave), .comparator_one_synced_i(src_n[0]),
        .comparator_two_synced_i(src_n[1]),
        .timer_postscaled_out_i(src_n[2]), .fault_input_pin_i(fault_n),
        .sleep_i(sleep), .wave_output_a_o(outs[0]),
        .wave_output_b_o(outs[1]), .wave_output_c_o(outs[2]),
        .wave_output_d_o(outs[3]), .fast_osc_keep_o(keep)
    );
    wss_gate_drv drv (.trip_i(!src_n[3]), .fault_n_o(fault_n));
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    // ----------------
    // bus and checks
    // ----------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, got);
        checks_done++;
        if (got !== ex)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic co(input int k, input logic [3:0] ex);
        repeat (k) @(posedge clk_i);
        chk("outputs", {28'h0, ex}, {28'h0, outs});
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do
            @(posedge clk_i);
        while (pready_o !== 1'h1 && ++n < 20);
        if (pready_o !== 1'h1)
        begin
            miscompares++;
            summarize();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h0, 12'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'h0, 12'h014, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("slave error", 32'h1, {31'h0, err});
        $display("reset test done");
        wave <= 1'h1;
        apb(1'h1, WSS_OFF_MODE, 32'h0000_0650);
        apb(1'h1, WSS_OFF_CTRL0, 32'h0000_0008);
        apb(1'h1, WSS_OFF_STEER, 32'h0000_00C3);
        apb(1'h0, WSS_OFF_STEER, 32'h0);
        chk("steer register", 32'h0000_00C3, rd);
        co(4, 4'hE);
        wave <= 1'h0;
        co(4, 4'hD);
        $display("steering test done");
        apb(1'h1, WSS_OFF_CTRL0, 32'h0000_0009);
        co(4, 4'h6);
        wave <= 1'h1;
        co(4, 4'h6);
        apb(1'h0, WSS_OFF_CTRL0, 32'h0);
        chk("control", 32'h0000_0009, rd);
        apb(1'h1, WSS_OFF_CTRL0, 32'h0000_0008);
        co(4, 4'hE);
        wave <= 1'h0;
        apb(1'h1, WSS_OFF_CTRL0, 32'h0000_000B);
        co(4, 4'h6);
        wave <= 1'h1;
        co(6, 4'hE);
        apb(1'h0, WSS_OFF_CTRL0, 32'h0);
        chk("control", 32'h0000_000A, rd);
        $display("software shutdown test done");
        apb(1'h1, WSS_OFF_CTRL0, 32'h0000_000C);
        for (int i = 0; i < WSS_NSRC; i++)
        begin
            apb(1'h1, WSS_OFF_SRCSEL, {28'h0, 4'hF ^ (4'h1 << i)});
            src_n[i] <= 1'h0;
            co(5, 4'hE);
            apb(1'h1, WSS_OFF_SRCSEL, {28'h0, 4'h1 << i});
            co(5, 4'h6);
            apb(1'h1, WSS_OFF_CTRL0, 32'h0000_0008);
            co(5, 4'hE);
            src_n[i] <= 1'h1;
            apb(1'h1, WSS_OFF_CTRL0, 32'h0000_000C);
        end
        $display("shutdown source test done");
        wave <= 1'h0;
        apb(1'h1, WSS_OFF_CTRL0, 32'h0000_0008);
        apb(1'h1, WSS_OFF_MODE, 32'h0000_0651);
        apb(1'h1, WSS_OFF_STEER, 32'h0000_00CF);
        co(5, 4'hD);
        wave <= 1'h1;
        co(5, 4'hA);
        $display("buffered steering test done");
        apb(1'h1, WSS_OFF_CTRL0, 32'h0000_0018);
        sleep <= 1'h1;
        co(5, 4'hA);
        chk("keep", 32'h1, {31'h0, keep});
        wave <= 1'h0;
        co(5, 4'h5);
        chk("keep", 32'h0, {31'h0, keep});
        sleep <= 1'h0;
        $display("sleep test done");
        apb(1'h1, WSS_OFF_MODE, 32'h0000_0650);
        apb(1'h1, WSS_OFF_STEER, 32'h0000_00C0);
        co(5, 4'hC);
        apb(1'h1, WSS_OFF_MODE, 32'h0000_0652);
        co(5, 4'h5);
        ce <= 1'h0;
        wave <= 1'h1;
        co(4, 4'h5);
        ce <= 1'h1;
        co(4, 4'hA);
        $display("mode and enable test done");
        summarize();
    end
endmodule // wss_top_tb_top
